// ---- logic/trcps_regs.sv ----
`timescale 1ns/1ps
module trcps_regs
   import trcps_pkg::*;
#(
   parameter logic [PART_W-1:0] PART_NUM = PART_NUM_DFLT, // Arbitrary
   parameter logic [DES0_W-1:0] DES0 = DES0_DFLT // Arbitrary
)
(
   input wire logic clk, // Clock, 100 MHz
   input wire logic rst, // Trace unit reset
   input wire logic pwr_good, // Core domain power good
   input wire logic state_lost, // Contents lost while off
   input wire logic sw_lock_locked, // Software lock state
   input wire logic acc_req, // Access request
   input wire logic acc_memmap, // 1 memory-mapped access
   input wire logic acc_sysreg, // 1 system-register access
   input wire logic acc_write, // 1 write, 0 read
   input wire logic [trcps_pkg::ADDR_W-1:0] acc_addr, // Word index
   input wire logic [trcps_pkg::DATA_W-1:0] acc_wdata, // Write data
   output logic acc_ready, // Request can be taken
   output logic acc_ack, // Response valid
   output logic acc_err, // Error response
   output logic [trcps_pkg::DATA_W-1:0] acc_rdata, // Read data
   output logic trc_req, // Trace register request
   output logic trc_write, // Trace register write
   output logic [trcps_pkg::ADDR_W-1:0] trc_addr, // Trace index
   output logic [trcps_pkg::DATA_W-1:0] trc_wdata, // Trace write data
   input wire logic trc_ack, // Trace register done
   input wire logic trc_err, // Trace register error
   input wire logic [trcps_pkg::DATA_W-1:0] trc_rdata, // Trace read data
   output logic power_flag, // Power status
   output logic sticky_flag // Sticky power-down flag
);
   import trcps_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      trcps_acc_t st;
      logic [DATA_W-1:0] rdata;
      logic err;
      logic from_rom;
      logic was_ident;
      logic was_sel1;
      logic trc_write;
      logic [ADDR_W-1:0] trc_addr;
      logic [DATA_W-1:0] trc_wdata;
   } trcps_regs_t;

   trcps_regs_t r_ff;
   trcps_regs_t nxt_r;

   logic take;
   logic hit_pdsr;
   logic hit_ident;
   logic hit_trace;
   logic clr_req;
   logic rom_en;
   logic [PID_W-1:0] rom_q;
   logic [DATA_W-1:0] pdsr_word;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign acc_ready = (r_ff.st == ACC_IDLE);
   assign take = acc_req && acc_ready;
   assign hit_pdsr = (acc_addr == IDX_PDSR);
   assign hit_ident = (acc_addr == IDX_PID0) || (acc_addr == IDX_PID1);
   assign hit_trace = (acc_addr >= IDX_TRACE_LO);
   assign rom_en = take && hit_ident && !acc_write && !acc_sysreg;

   // No read-clear under a memory-mapped lock or with the domain off
   assign clr_req = take && hit_pdsr && !acc_write && power_flag
                    && !(acc_memmap && sw_lock_locked);

   always_comb
   begin
      pdsr_word = ZERO_WORD;
      pdsr_word[PDSR_POWER_BIT] = power_flag;
      pdsr_word[PDSR_STICKY_BIT] = sticky_flag;
   end

   // ----------------------------------------------------------------
   // Access sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_r = r_ff;
      unique case (r_ff.st)
         ACC_IDLE:
         begin
            if (take)
            begin
               nxt_r.st = ACC_RESP;
               nxt_r.rdata = ZERO_WORD;
               nxt_r.err = 1'b0;
               nxt_r.from_rom = 1'b0;
               nxt_r.was_ident = 1'b0;
               nxt_r.was_sel1 = (acc_addr == IDX_PID1);
               if (hit_pdsr)
               begin
                  // Writes to the status word are ignored
                  if (!acc_write)
                     nxt_r.rdata = pdsr_word;
               end
               else if (hit_ident)
               begin
                  nxt_r.was_ident = 1'b1;
                  nxt_r.err = acc_sysreg;
                  nxt_r.from_rom = !acc_write && !acc_sysreg;
               end
               else if (hit_trace)
               begin
                  if (power_flag)
                  begin
                     nxt_r.st = ACC_FWD;
                     nxt_r.trc_write = acc_write;
                     nxt_r.trc_addr = acc_addr;
                     nxt_r.trc_wdata = acc_wdata;
                  end
                  else
                     nxt_r.err = 1'b1;
               end
               else
                  nxt_r.err = 1'b1;
            end
         end
         ACC_FWD:
         begin
            if (trc_ack)
            begin
               nxt_r.st = ACC_RESP;
               nxt_r.err = trc_err;
               nxt_r.rdata = trc_write ? ZERO_WORD : trc_rdata;
            end
            else if (!power_flag)
            begin
               // Domain dropped mid-access: end it with an error
               nxt_r.st = ACC_RESP;
               nxt_r.err = 1'b1;
            end
         end
         ACC_RESP:
            nxt_r.st = ACC_IDLE;
         default:
            nxt_r.st = ACC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         r_ff <= '0;
      else
         r_ff <= nxt_r;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign acc_ack = (r_ff.st == ACC_RESP);
   assign acc_err = acc_ack && r_ff.err;
   assign acc_rdata = !acc_ack ? ZERO_WORD
                    : r_ff.from_rom ? {{(DATA_W-PID_W){1'b0}}, rom_q}
                    : r_ff.rdata;
   assign trc_req = (r_ff.st == ACC_FWD);
   assign trc_write = r_ff.trc_write;
   assign trc_addr = r_ff.trc_addr;
   assign trc_wdata = r_ff.trc_wdata;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   trcps_sticky i_trcps_sticky
   (
      .clk(clk),
      .rst(rst),
      .pwr_good(pwr_good),
      .state_lost(state_lost),
      .clr_req(clr_req),
      .power_flag(power_flag),
      .sticky_flag(sticky_flag)
   );

   trcps_idrom #(
      .PART_NUM(PART_NUM),
      .DES0(DES0)
   ) i_trcps_idrom
   (
      .clk(clk),
      .rst(rst),
      .rd_en(rom_en),
      .rd_sel(acc_addr == IDX_PID1),
      .rd_data(rom_q)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_clr_after_read;
      @(posedge clk) disable iff (rst)
      clr_req |=> (!sticky_flag || !power_flag);
   endproperty
   a_clr_after_read: assert property (p_clr_after_read)
      else $error("sticky flag not cleared after status read");

   property p_no_clr_locked;
      @(posedge clk) disable iff (rst)
      (take && hit_pdsr && !acc_write && acc_memmap && sw_lock_locked
         && pwr_good && power_flag) |=> $stable(sticky_flag);
   endproperty
   a_no_clr_locked: assert property (p_no_clr_locked)
      else $error("locked memory-mapped read cleared sticky flag");

   property p_ident_hi_zero;
      @(posedge clk) disable iff (rst)
      (acc_ack && r_ff.was_ident) |-> (acc_rdata[DATA_W-1:PID_W] == '0);
   endproperty
   a_ident_hi_zero: assert property (p_ident_hi_zero)
      else $error("ident upper bits not zero");

   property p_ident_part;
      @(posedge clk) disable iff (rst)
      (take && (acc_addr == IDX_PID0) && !acc_write && !acc_sysreg)
         |=> acc_ack && (acc_rdata[PID_W-1:0] == PART_NUM[PID_W-1:0]);
   endproperty
   a_ident_part: assert property (p_ident_part)
      else $error("ident zero does not hold part number low byte");

   property p_ident_part_hi;
      @(posedge clk) disable iff (rst)
      (take && (acc_addr == IDX_PID1) && !acc_write && !acc_sysreg)
         |=> (acc_rdata[PID_W-1:0] == {DES0, PART_NUM[PART_W-1:PID_W]});
   endproperty
   a_ident_part_hi: assert property (p_ident_part_hi)
      else $error("ident one does not hold part number top nibble");

   property p_sysreg_err;
      @(posedge clk) disable iff (rst)
      (take && hit_ident && acc_sysreg) |=> (acc_ack && acc_err);
   endproperty
   a_sysreg_err: assert property (p_sysreg_err)
      else $error("system-register ident access not refused");

   property p_ident_write;
      @(posedge clk) disable iff (rst)
      (take && hit_ident && acc_write && !acc_sysreg)
         |=> (acc_ack && !acc_err && acc_rdata == ZERO_WORD);
   endproperty
   a_ident_write: assert property (p_ident_write)
      else $error("ident write not ignored");

   property p_unpowered_err;
      @(posedge clk) disable iff (rst)
      (take && hit_trace && !power_flag) |=> (acc_ack && acc_err && !trc_req);
   endproperty
   a_unpowered_err: assert property (p_unpowered_err)
      else $error("trace access while unpowered not errored");

   property p_pdsr_word;
      @(posedge clk) disable iff (rst)
      (take && hit_pdsr && !acc_write) |=> acc_ack && !acc_err
         && (acc_rdata == {{(DATA_W-2){1'b0}}, $past(sticky_flag),
                           $past(power_flag)});
   endproperty
   a_pdsr_word: assert property (p_pdsr_word)
      else $error("status word does not show the flags");

   property p_fwd_req;
      @(posedge clk) disable iff (rst)
      (take && hit_trace && power_flag)
         |=> trc_req && !acc_ack && (trc_addr == $past(acc_addr));
   endproperty
   a_fwd_req: assert property (p_fwd_req)
      else $error("powered trace access not forwarded");

   property p_rom_sel;
      @(posedge clk) disable iff (rst)
      (acc_ack && r_ff.from_rom && r_ff.was_sel1)
         |-> (acc_rdata[PID_W-1:0] == {DES0, PART_NUM[PART_W-1:PID_W]});
   endproperty
   a_rom_sel: assert property (p_rom_sel)
      else $error("ident one byte not selected");

   property p_drop_err;
      @(posedge clk) disable iff (rst)
      (trc_req && !trc_ack && !power_flag) |=> (acc_ack && acc_err);
   endproperty
   a_drop_err: assert property (p_drop_err)
      else $error("forward not ended with error after power loss");

endmodule : trcps_regs

// ---- logic/trcps_pkg.sv ----
package trcps_pkg;

   // ----------------------------------------------------------------
   // Register word indexes on the access port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] IDX_PDSR = 10'h000;
   localparam logic [ADDR_W-1:0] IDX_PID0 = 10'h001;
   localparam logic [ADDR_W-1:0] IDX_PID1 = 10'h002;
   localparam logic [ADDR_W-1:0] IDX_TRACE_LO = 10'h100;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int PDSR_POWER_BIT = 0;
   localparam int PDSR_STICKY_BIT = 1;
   localparam int PID_W = 8;
   localparam int PART_W = 12;
   localparam int DES0_W = 4;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic STICKY_RST = 1'b1;
   localparam logic LOST_RST = 1'b1;

   // ----------------------------------------------------------------
   // Implementer identity values (arbitrary)
   // ----------------------------------------------------------------
   localparam logic [PART_W-1:0] PART_NUM_DFLT = 12'h5A3;
   localparam logic [DES0_W-1:0] DES0_DFLT = 4'h6;

   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ACC_IDLE = 2'b00,
      ACC_FWD = 2'b01,
      ACC_RESP = 2'b11
   } trcps_acc_t;

   typedef enum logic
   {
      PWR_OFF = 1'b0,
      PWR_ON = 1'b1
   } trcps_pwr_t;

endpackage : trcps_pkg

// ---- logic/trcps_idrom.sv ----
`timescale 1ns/1ps
module trcps_idrom
   import trcps_pkg::*;
#(
   parameter logic [PART_W-1:0] PART_NUM = PART_NUM_DFLT,
   parameter logic [DES0_W-1:0] DES0 = DES0_DFLT
)
(
   input wire logic clk, // Clock
   input wire logic rst, // Sync reset
   input wire logic rd_en, // Read strobe
   input wire logic rd_sel, // 0 ident zero, 1 ident one
   output logic [trcps_pkg::PID_W-1:0] rd_data // Registered byte
);
   import trcps_pkg::*;

   typedef struct packed
   {
      logic [PID_W-1:0] q;
   } trcps_rom_t;

   trcps_rom_t rom_ff;
   trcps_rom_t nxt_rom;

   always_comb
   begin
      nxt_rom = rom_ff;
      if (rd_en)
      begin
         // Low part number byte, then designer nibble and high part
         nxt_rom.q = rd_sel ? {DES0, PART_NUM[PART_W-1:PID_W]}
                            : PART_NUM[PID_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rom_ff <= '0;
      else
         rom_ff <= nxt_rom;
   end

   assign rd_data = rom_ff.q;

endmodule : trcps_idrom

// ---- logic/trcps_sticky.sv ----
`timescale 1ns/1ps
module trcps_sticky
   import trcps_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Trace unit reset
   input wire logic pwr_good, // Core domain powered
   input wire logic state_lost, // Contents lost while off
   input wire logic clr_req, // Read-clear pulse
   output logic power_flag, // Registered power status
   output logic sticky_flag // Registered sticky flag
);
   import trcps_pkg::*;

   typedef struct packed
   {
      trcps_pwr_t mode;
      logic sticky;
      logic saved;
      logic lost;
   } trcps_stk_t;

   trcps_stk_t s_ff;
   trcps_stk_t nxt_s;

   always_comb
   begin
      nxt_s = s_ff;
      if (pwr_good)
      begin
         if (s_ff.mode == PWR_OFF)
         begin
            // Power back: lost forces 1, retained restores old value
            nxt_s.mode = PWR_ON;
            nxt_s.sticky = (s_ff.lost | state_lost) ? 1'b1
                                                    : s_ff.saved;
            nxt_s.lost = 1'b0;
         end
         else if (clr_req)
            nxt_s.sticky = 1'b0;
      end
      else
      begin
         if (s_ff.mode == PWR_ON)
         begin
            nxt_s.mode = PWR_OFF;
            nxt_s.saved = s_ff.sticky;
         end
         // Off: show 1 once loss is known, 0 while unknown
         nxt_s.lost = s_ff.lost | state_lost;
         nxt_s.sticky = s_ff.lost | state_lost;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_ff.mode <= PWR_OFF;
         s_ff.sticky <= STICKY_RST;
         s_ff.saved <= STICKY_RST;
         s_ff.lost <= LOST_RST;
      end
      else
         s_ff <= nxt_s;
   end

   assign power_flag = (s_ff.mode == PWR_ON);
   assign sticky_flag = s_ff.sticky;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_rst_sets;
      @(posedge clk) rst |=> sticky_flag;
   endproperty
   a_rst_sets: assert property (p_rst_sets)
      else $error("sticky flag not set by reset");

   property p_lost_return;
      @(posedge clk) disable iff (rst)
      (!power_flag && s_ff.lost && pwr_good) |=> (sticky_flag && power_flag);
   endproperty
   a_lost_return: assert property (p_lost_return)
      else $error("sticky flag not forced after lost state");

   property p_retain_restore;
      @(posedge clk) disable iff (rst)
      (!power_flag && !s_ff.lost && !state_lost && pwr_good)
         |=> (sticky_flag == $past(s_ff.saved)) && power_flag;
   endproperty
   a_retain_restore: assert property (p_retain_restore)
      else $error("sticky flag not restored after retention");

   property p_off_shows_lost;
      @(posedge clk) disable iff (rst)
      (!pwr_good && state_lost) |=> (sticky_flag && !power_flag);
   endproperty
   a_off_shows_lost: assert property (p_off_shows_lost)
      else $error("known loss not shown while off");

   property p_power_follows;
      @(posedge clk) disable iff (rst)
      $rose(pwr_good) |-> !power_flag ##1 power_flag;
   endproperty
   a_power_follows: assert property (p_power_follows)
      else $error("power flag does not follow power good");

endmodule : trcps_sticky

// ---- verif/trcps_regs_test.sv ----
`timescale 1ns/1ps
module trcps_regs_test
   import trcps_pkg::*;
   ;
   // ----------------------------------------------------------------
   // Bench signals
   // ----------------------------------------------------------------
   localparam logic [PART_W-1:0] T_PART = 12'h3C7; // Arbitrary
   localparam logic [DES0_W-1:0] T_DES0 = 4'h9; // Arbitrary
   logic clk, rst, pwr_good, state_lost, sw_lock_locked;
   logic acc_req, acc_memmap, acc_sysreg, acc_write;
   logic [ADDR_W-1:0] acc_addr;
   logic [DATA_W-1:0] acc_wdata, acc_rdata, trc_wdata, trc_rdata;
   logic acc_ready, acc_ack, acc_err, trc_req, trc_write, trc_ack, trc_err;
   logic [ADDR_W-1:0] trc_addr, seen_addr;
   logic power_flag, sticky_flag, trc_fail, trc_hit, seen_write, er;
   logic [DATA_W-1:0] seen_wdata, rd;
   logic [15:0] pid;
   int error_cnt, checks_done, trc_lat, tcnt;

   trcps_regs #(.PART_NUM(T_PART), .DES0(T_DES0)) i_trcps_regs (
      .clk(clk), .rst(rst), .pwr_good(pwr_good), .state_lost(state_lost),
      .sw_lock_locked(sw_lock_locked), .acc_req(acc_req),
      .acc_memmap(acc_memmap), .acc_sysreg(acc_sysreg),
      .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
      .acc_ready(acc_ready), .acc_ack(acc_ack), .acc_err(acc_err),
      .acc_rdata(acc_rdata), .trc_req(trc_req), .trc_write(trc_write),
      .trc_addr(trc_addr), .trc_wdata(trc_wdata), .trc_ack(trc_ack),
      .trc_err(trc_err), .trc_rdata(trc_rdata), .power_flag(power_flag),
      .sticky_flag(sticky_flag));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Trace register file stand-in
   // ----------------------------------------------------------------
   function automatic logic [DATA_W-1:0] trc_word(input logic [9:0] a);
      return {22'h30F0F5, a};
   endfunction : trc_word

   always @(posedge clk)
   begin
      trc_hit = trc_req && !trc_ack && tcnt >= trc_lat;
      trc_ack <= trc_hit;
      trc_err <= trc_hit && trc_fail;
      trc_rdata <= trc_hit ? trc_word(trc_addr) : ~trc_word(trc_addr);
      tcnt <= (trc_req && !trc_hit && !trc_ack) ? tcnt + 1 : 0;
      if (trc_hit)
      begin
         seen_addr <= trc_addr;
         seen_write <= trc_write;
         seen_wdata <= trc_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [9:0] a,
                      input logic [31:0] wd, input logic mm, input logic sr);
      int n;
      logic rdy;
      @(posedge clk);
      acc_req <= 1'b1;
      acc_write <= wr;
      acc_addr <= a;
      acc_wdata <= wd;
      acc_memmap <= mm;
      acc_sysreg <= sr;
      n = 0;
      do
      begin
         @(negedge clk);
         rdy = acc_ready;
         @(posedge clk);
         n++;
      end while (!rdy && n < 50);
      acc_req <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end while (acc_ack !== 1'b1 && n < 60);
      chk("acc_ack", 32'h1, {31'h0, acc_ack});
      chk("acc_ready at ack", 32'h0, {31'h0, acc_ready});
      rd = acc_rdata;
      er = acc_err;
   endtask : acc

   task automatic rchk(input string what, input logic wr, input logic [9:0] a,
                       input logic mm, input logic [31:0] ed, input logic ee);
      acc(wr, a, 32'hFFFF_FFFF, mm, 1'b0);
      chk({what, " data"}, ed, rd);
      chk({what, " err"}, {31'h0, ee}, {31'h0, er});
   endtask : rchk

   task automatic flags(input string what, input logic p, input logic s);
      chk(what, {30'h0, s, p}, {30'h0, sticky_flag, power_flag});
   endtask : flags

   task automatic pwr(input logic g, input logic lost);
      @(posedge clk);
      pwr_good <= g;
      state_lost <= lost;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : pwr

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask : do_reset

   task automatic test_done(input string name);
      $display("Test %s finished, mismatches so far %0d", name, error_cnt);
   endtask : test_done

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1; pwr_good = 1'b1; state_lost = 1'b0; sw_lock_locked = 1'b0;
      acc_req = 1'b0; acc_memmap = 1'b0; acc_sysreg = 1'b0; acc_write = 1'b0;
      acc_addr = '0; acc_wdata = '0;
      trc_lat = 0; trc_fail = 1'b0; pid = '0;
      error_cnt = 0; checks_done = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      flags("flags after reset", 1'b1, 1'b1);
      rchk("status write", 1'b1, IDX_PDSR, 1'b1, 32'h0, 1'b0);
      rchk("status mm open", 1'b0, IDX_PDSR, 1'b1, 32'h3, 1'b0);
      rchk("status cleared", 1'b0, IDX_PDSR, 1'b1, 32'h1, 1'b0);
      test_done("reset");

      do_reset();
      flags("flags after reset 2", 1'b1, 1'b1);
      @(posedge clk);
      sw_lock_locked <= 1'b1;
      rchk("locked mm 1", 1'b0, IDX_PDSR, 1'b1, 32'h3, 1'b0);
      rchk("locked mm 2", 1'b0, IDX_PDSR, 1'b1, 32'h3, 1'b0);
      rchk("locked dbg 1", 1'b0, IDX_PDSR, 1'b0, 32'h3, 1'b0);
      rchk("locked dbg 2", 1'b0, IDX_PDSR, 1'b0, 32'h1, 1'b0);
      @(posedge clk);
      sw_lock_locked <= 1'b0;
      test_done("lock");

      for (int m = 0; m < 2; m++)
      begin
         rchk("ident zero", 1'b0, IDX_PID0, m[0], {24'h0, T_PART[7:0]},
              1'b0);
         pid[7:0] = rd[7:0];
         rchk("ident one", 1'b0, IDX_PID1, m[0], {24'h0, T_DES0, T_PART[11:8]},
              1'b0);
         pid[15:8] = rd[7:0];
         chk("part number", {20'h0, T_PART},
             {20'h0, pid[11:0]});
      end
      rchk("ident write", 1'b1, IDX_PID0, 1'b1, 32'h0, 1'b0);
      rchk("ident reread", 1'b0, IDX_PID0, 1'b1, {24'h0, T_PART[7:0]},
           1'b0);
      acc(1'b0, IDX_PID1, 32'h0, 1'b0, 1'b1);
      chk("ident sysreg err", 32'h1, {31'h0, er});
      acc(1'b0, 10'h003, 32'h0, 1'b1, 1'b0);
      chk("unmapped 003 err", 32'h1, {31'h0, er});
      acc(1'b0, 10'h0FF, 32'h0, 1'b0, 1'b0);
      chk("unmapped 0FF err", 32'h1, {31'h0, er});
      test_done("ident");

      for (int l = 0; l < 2; l++)
      begin
         trc_lat = 3 * l;
         rchk("trace lo", 1'b0, IDX_TRACE_LO, 1'b1, trc_word(10'h100),
              1'b0);
         rchk("trace hi", 1'b0, 10'h3FF, 1'b0, trc_word(10'h3FF),
              1'b0);
         chk("trace addr", {22'h0, 10'h3FF}, {22'h0, seen_addr});
      end
      acc(1'b1, 10'h155, 32'hDEAD_BEEF, 1'b1, 1'b0);
      chk("trace wr err", 32'h0, {31'h0, er});
      chk("trace wr data", 32'hDEAD_BEEF, seen_wdata);
      chk("trace wr flag", 32'h1, {31'h0, seen_write});
      trc_fail = 1'b1;
      acc(1'b0, 10'h180, 32'h0, 1'b1, 1'b0);
      chk("trace err pass", 32'h1, {31'h0, er});
      trc_fail = 1'b0;
      test_done("trace");

      pwr(1'b0, 1'b0);
      flags("off unknown", 1'b0, 1'b0);
      acc(1'b0, 10'h120, 32'h0, 1'b0, 1'b0);
      chk("off trace err", 32'h1, {31'h0, er});
      pwr(1'b1, 1'b0);
      flags("retained zero", 1'b1, 1'b0);
      pwr(1'b0, 1'b1);
      flags("off lost", 1'b0, 1'b1);
      rchk("off status", 1'b0, IDX_PDSR, 1'b0, 32'h2, 1'b0);
      flags("off no clear", 1'b0, 1'b1);
      pwr(1'b1, 1'b1);
      @(posedge clk);
      state_lost <= 1'b0;
      flags("return lost", 1'b1, 1'b1);
      rchk("trace after loss", 1'b0, 10'h101, 1'b1, trc_word(10'h101),
           1'b0);
      rchk("status lost", 1'b0, IDX_PDSR, 1'b0, 32'h3, 1'b0);
      do_reset();
      pwr(1'b0, 1'b0);
      pwr(1'b1, 1'b0);
      flags("retained one", 1'b1, 1'b1);
      trc_lat = 20;
      fork
         acc(1'b0, 10'h200, 32'h0, 1'b1, 1'b0);
         begin
            repeat (4) @(posedge clk);
            pwr_good <= 1'b0;
         end
      join
      chk("drop mid access", 32'h1, {31'h0, er});
      pwr(1'b1, 1'b0);
      trc_lat = 0;
      test_done("power");
      complete_run();
   end

endmodule : trcps_regs_test
